// ==== hdl/fskr_regs.svh ====
// Purpose: Register indices, bit positions and reset values of the FSK reload block
// Assumes: Byte address of a register is four times its index
// Notes:   Coefficient registers are 16 bits wide and sit in the low half of the word
`ifndef FSKR_REGS_SVH
`define FSKR_REGS_SVH

// Register indices (byte address = index * 4)
`define FSKR_IDX_SPACE_AMP      10'h063
`define FSKR_IDX_SPACE_FREQ     10'h064
`define FSKR_IDX_MARK_AMP       10'h065
`define FSKR_IDX_MARK_FREQ      10'h066
`define FSKR_IDX_S2M_GAIN       10'h067
`define FSKR_IDX_M2S_GAIN       10'h068
`define FSKR_IDX_OSC_CTRL       10'h020
`define FSKR_IDX_FSK_CTRL       10'h06c
`define FSKR_IDX_FREQUENCY_COEFF_A_AMP       10'h070
`define FSKR_IDX_FREQUENCY_COEFF_A_FREQ      10'h071
`define FSKR_IDX_STATUS         10'h072

// Control bit positions
`define FSKR_BIT_RELOAD_EN      6
`define FSKR_BIT_FSK_EN         6

// Status bit positions
`define FSKR_BIT_ST_ACTIVE      0
`define FSKR_BIT_ST_LASTSYM     1
`define FSKR_BIT_ST_SYMVALID    2

// Reset values
`define FSKR_RST_COEFF          16'h0000
`define FSKR_RST_WORD           32'h0000_0000

`endif

// ==== hdl/fskr_pkg.sv ====
// Purpose: Types shared by the FSK reload block
// Assumes: Coefficients are 16-bit twos-complement words
// Notes:   Load bundle goes to the oscillator-one core
package fskr_pkg;

  // Coefficient set handed to oscillator one on each timer expiry
  typedef struct packed {
    logic [15:0] amp;        // Amplitude coefficient
    logic [15:0] freq;       // Frequency coefficient
    logic [15:0] gain;       // Transition gain correction factor
    logic        gainValid;  // Gain factor applies to this load
    logic        symbol;     // Symbol being sent, 1 = mark
    logic        enhanced;   // Load came from the FSK coefficient set
  } fskr_load_t;

  // AHB-Lite address phase captured for the data phase
  typedef struct packed {
    logic       write;       // Data phase is a write
    logic [9:0] index;       // Word index of the access
  } fskr_ahb_t;

endpackage

// ==== hdl/fskr_osc_reload.sv ====
// Purpose: Enhanced FSK reload control for oscillator one, with AHB-Lite registers
// Assumes: Timer expiry is a one-cycle pulse; symbol input is valid with it
// Notes:   Zero-wait-state slave; unmapped reads return zero, unmapped writes are dropped
//          Gain factor is only passed out; the oscillator core applies it
//
// Notes on behaviour
// - Enhanced mode only while both fsk and reload enable bits read one.
// - Space symbol at timer expiry loads the space amplitude coefficient.
// - Space symbol at timer expiry loads the space frequency coefficient.
// - Mark symbol at timer expiry loads the mark amplitude coefficient.
// - Mark symbol at timer expiry loads the mark frequency coefficient.
// - Space-to-mark change applies the space-to-mark gain correction factor.
// - Mark-to-space change applies the mark-to-space gain correction factor.
`timescale 1ns/10ps

module fskr_osc_reload
  import fskr_pkg::*;
(
  input  wire logic        clk_sys,        // System clock, 20 MHz
  input  wire logic        rstn,           // Synchronous reset, active low
  input  wire logic        hsel,           // AHB slave select
  input  wire logic [31:0] haddr,          // AHB address
  input  wire logic [1:0]  htrans,         // AHB transfer type
  input  wire logic        hwrite,         // AHB write flag
  input  wire logic [2:0]  hsize,          // AHB transfer size
  input  wire logic [31:0] hwdata,         // AHB write data
  input  wire logic        hready,         // AHB bus ready
  output logic      [31:0] hrdata,         // AHB read data
  output logic             hreadyout,      // AHB slave ready
  output logic             hresp,          // AHB response, always OKAY
  input  wire logic        osc1TimerExpire,// Oscillator-one active timer expiry pulse
  input  wire logic        fskSymbol,      // Symbol to send next, 1 = mark
  output logic             osc1Load,       // Pulse: new coefficients valid
  output fskr_load_t       osc1LoadData    // Coefficients for oscillator one
);

`include "fskr_regs.svh"

  // Register state
  logic [15:0] spaceAmp_q;
  logic [15:0] spaceFreq_q;
  logic [15:0] markAmp_q;
  logic [15:0] markFreq_q;
  logic [15:0] s2mGain_q;
  logic [15:0] m2sGain_q;
  logic [15:0] osc1Amp_q;
  logic [15:0] osc1Freq_q;
  logic        fskEnable_q;
  logic        reloadEnable_q;
  logic        lastSym_q;
  logic        symValid_q;
  logic        active_q;
  fskr_ahb_t   dphase_q;
  logic        dphaseValid_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic        osc1Load_q;
  fskr_load_t  loadData_q;

  // Address phase decode
  // Addresses above the 4 KB window are unmapped, so aliases never hit a register
  wire         addrTake  = hsel & htrans[1] & hready;
  wire  [9:0]  addrIndex = haddr[11:2];
  wire         addrHigh  = |haddr[31:12];
  fskr_ahb_t   aphase_d;
  assign aphase_d.write = hwrite;
  assign aphase_d.index = addrIndex;

  // Data phase write strobes
  wire         wrGo      = dphaseValid_q & dphase_q.write;
  wire  [9:0]  wrIdx     = dphase_q.index;
  wire         wrSpAmp   = wrGo & (wrIdx == `FSKR_IDX_SPACE_AMP);
  wire         wrSpFreq  = wrGo & (wrIdx == `FSKR_IDX_SPACE_FREQ);
  wire         wrMkAmp   = wrGo & (wrIdx == `FSKR_IDX_MARK_AMP);
  wire         wrMkFreq  = wrGo & (wrIdx == `FSKR_IDX_MARK_FREQ);
  wire         wrS2m     = wrGo & (wrIdx == `FSKR_IDX_S2M_GAIN);
  wire         wrM2s     = wrGo & (wrIdx == `FSKR_IDX_M2S_GAIN);
  wire         wrOscCtl  = wrGo & (wrIdx == `FSKR_IDX_OSC_CTRL);
  wire         wrFskCtl  = wrGo & (wrIdx == `FSKR_IDX_FSK_CTRL);
  wire         wrO1Amp   = wrGo & (wrIdx == `FSKR_IDX_FREQUENCY_COEFF_A_AMP);
  wire         wrO1Freq  = wrGo & (wrIdx == `FSKR_IDX_FREQUENCY_COEFF_A_FREQ);

  // Next values of the software registers
  wire  [15:0] spaceAmp_d   = wrSpAmp  ? hwdata[15:0] : spaceAmp_q;
  wire  [15:0] spaceFreq_d  = wrSpFreq ? hwdata[15:0] : spaceFreq_q;
  wire  [15:0] markAmp_d    = wrMkAmp  ? hwdata[15:0] : markAmp_q;
  wire  [15:0] markFreq_d   = wrMkFreq ? hwdata[15:0] : markFreq_q;
  wire  [15:0] s2mGain_d    = wrS2m    ? hwdata[15:0] : s2mGain_q;
  wire  [15:0] m2sGain_d    = wrM2s    ? hwdata[15:0] : m2sGain_q;
  wire  [15:0] osc1Amp_d    = wrO1Amp  ? hwdata[15:0] : osc1Amp_q;
  wire  [15:0] osc1Freq_d   = wrO1Freq ? hwdata[15:0] : osc1Freq_q;
  wire         reloadEn_d   = wrOscCtl ? hwdata[`FSKR_BIT_RELOAD_EN] : reloadEnable_q;
  wire         fsk_enhanced_enable_d      = wrFskCtl ? hwdata[`FSKR_BIT_FSK_EN] : fskEnable_q;

  // Enhanced mode qualifier
  // Either bit alone leaves oscillator one on its normal reload path
  wire         enhanced     = fskEnable_q & reloadEnable_q;

  // Coefficient selection on timer expiry
  wire  [15:0] selAmp  = !enhanced ? osc1Amp_q :
                         fskSymbol ? markAmp_q  :
                                     spaceAmp_q;
  wire  [15:0] selFreq = !enhanced ? osc1Freq_q :
                         fskSymbol ? markFreq_q  :
                                     spaceFreq_q;
  // Gain stays zero unless a real symbol change happens in enhanced mode
  wire         symChange = enhanced & symValid_q & (fskSymbol != lastSym_q);
  wire  [15:0] selGain   = !symChange ? `FSKR_RST_COEFF :
                           fskSymbol  ? s2mGain_q :
                                        m2sGain_q;

  fskr_load_t  load_d;
  assign load_d.amp       = selAmp;
  assign load_d.freq      = selFreq;
  assign load_d.gain      = selGain;
  assign load_d.gainValid = symChange;
  assign load_d.symbol    = fskSymbol;
  assign load_d.enhanced  = enhanced;

  // Symbol history valid flag, cleared whenever enhanced mode is off
  // A stale history would apply a gain to the first symbol after re-entry
  wire         symValid_d = enhanced & (symValid_q | osc1TimerExpire);
  wire         lastSym_d  = (enhanced & osc1TimerExpire) ? fskSymbol : lastSym_q;

  // Read view of each writable register as it will stand after a pending write
  // Forwarding lets a read right after a write see new data without a wait state
  wire  [31:0] statusWord = {29'h0000_0000, symValid_q, lastSym_q, enhanced};
  wire  [31:0] oscCtlWord = {25'h000_0000, reloadEn_d, 6'h00};
  wire  [31:0] fskCtlWord = {25'h000_0000, fsk_enhanced_enable_d, 6'h00};
  wire  [31:0] rdMux =
      addrHigh                              ? `FSKR_RST_WORD :
      (addrIndex == `FSKR_IDX_SPACE_AMP)    ? {16'h0000, spaceAmp_d} :
      (addrIndex == `FSKR_IDX_SPACE_FREQ)   ? {16'h0000, spaceFreq_d} :
      (addrIndex == `FSKR_IDX_MARK_AMP)     ? {16'h0000, markAmp_d} :
      (addrIndex == `FSKR_IDX_MARK_FREQ)    ? {16'h0000, markFreq_d} :
      (addrIndex == `FSKR_IDX_S2M_GAIN)     ? {16'h0000, s2mGain_d} :
      (addrIndex == `FSKR_IDX_M2S_GAIN)     ? {16'h0000, m2sGain_d} :
      (addrIndex == `FSKR_IDX_OSC_CTRL)     ? oscCtlWord :
      (addrIndex == `FSKR_IDX_FSK_CTRL)     ? fskCtlWord :
      (addrIndex == `FSKR_IDX_FREQUENCY_COEFF_A_AMP)     ? {16'h0000, osc1Amp_d} :
      (addrIndex == `FSKR_IDX_FREQUENCY_COEFF_A_FREQ)    ? {16'h0000, osc1Freq_d} :
      (addrIndex == `FSKR_IDX_STATUS)       ? statusWord :
                                              `FSKR_RST_WORD;
  wire  [31:0] hrdata_d = (addrTake & !hwrite) ? rdMux : hrdata_q;

  // Bus phase tracking and read data
  // hreadyout stays low through reset so no transfer is taken early
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dphaseValid_q <= 1'b0;
      dphase_q      <= '0;
      hrdata_q      <= `FSKR_RST_WORD;
      hreadyout_q   <= 1'b0;
      hresp_q       <= 1'b0;
    end else begin
      dphaseValid_q <= addrTake & !addrHigh;
      dphase_q      <= aphase_d;
      hrdata_q      <= hrdata_d;
      hreadyout_q   <= 1'b1;
      hresp_q       <= 1'b0;  // Only OKAY is ever returned
    end
  end

  // Coefficient registers, loaded by software before enabling the mode
  // Contents read zero from reset until software writes them
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      spaceAmp_q  <= `FSKR_RST_COEFF;
      spaceFreq_q <= `FSKR_RST_COEFF;
      markAmp_q   <= `FSKR_RST_COEFF;
      markFreq_q  <= `FSKR_RST_COEFF;
      s2mGain_q   <= `FSKR_RST_COEFF;
      m2sGain_q   <= `FSKR_RST_COEFF;
      osc1Amp_q   <= `FSKR_RST_COEFF;
      osc1Freq_q  <= `FSKR_RST_COEFF;
    end else begin
      spaceAmp_q  <= spaceAmp_d;
      spaceFreq_q <= spaceFreq_d;
      markAmp_q   <= markAmp_d;
      markFreq_q  <= markFreq_d;
      s2mGain_q   <= s2mGain_d;
      m2sGain_q   <= m2sGain_d;
      osc1Amp_q   <= osc1Amp_d;
      osc1Freq_q  <= osc1Freq_d;
    end
  end

  // Enable bits and symbol history
  // active_q is a delayed copy of the mode, used to see mode entry
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fskEnable_q    <= 1'b0;
      reloadEnable_q <= 1'b0;
      symValid_q     <= 1'b0;
      lastSym_q      <= 1'b0;
      active_q       <= 1'b0;
    end else begin
      fskEnable_q    <= fsk_enhanced_enable_d;
      reloadEnable_q <= reloadEn_d;
      symValid_q     <= symValid_d;
      lastSym_q      <= lastSym_d;
      active_q       <= enhanced;
    end
  end

  // Reload output to oscillator one
  // Load data holds between expiries so the core may sample it late
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      osc1Load_q <= 1'b0;
      loadData_q <= '0;
    end else begin
      osc1Load_q <= osc1TimerExpire;
      if (osc1TimerExpire) begin
        loadData_q <= load_d;
      end
    end
  end

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = hresp_q;
  assign osc1Load     = osc1Load_q;
  assign osc1LoadData = loadData_q;

  // Checks on the reload behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_MODE_NEEDS_BOTH: assert property (
    osc1Load |-> (osc1LoadData.enhanced == $past(fskEnable_q & reloadEnable_q)))
    else $error("Enhanced flag does not match both enables");

  AST_SPACE_AMP: assert property (
    (osc1TimerExpire && enhanced && !fskSymbol) |=> (osc1LoadData.amp == $past(spaceAmp_q)))
    else $error("Space amplitude not loaded");

  AST_SPACE_FREQ: assert property (
    (osc1TimerExpire && enhanced && !fskSymbol) |=> (osc1LoadData.freq == $past(spaceFreq_q)))
    else $error("Space frequency not loaded");

  AST_MARK_AMP: assert property (
    (osc1TimerExpire && enhanced && fskSymbol) |=> osc1Load && (osc1LoadData.amp == $past(markAmp_q)))
    else $error("Mark amplitude not loaded");

  AST_MARK_FREQ: assert property (
    (osc1TimerExpire && enhanced && fskSymbol) |=> (osc1LoadData.freq == $past(markFreq_q)))
    else $error("Mark frequency not loaded");

  AST_S2M_GAIN: assert property (
    (osc1TimerExpire && enhanced && fskSymbol && symValid_q && !lastSym_q)
      |=> osc1LoadData.gainValid && (osc1LoadData.gain == $past(s2mGain_q)))
    else $error("Space-to-mark gain not applied");

  AST_M2S_GAIN: assert property (
    (osc1TimerExpire && enhanced && !fskSymbol && symValid_q && lastSym_q)
      |=> osc1LoadData.gainValid && (osc1LoadData.gain == $past(m2sGain_q)))
    else $error("Mark-to-space gain not applied");

  AST_NORMAL_RELOAD: assert property (
    (osc1TimerExpire && !enhanced) |=> !osc1LoadData.gainValid
      && (osc1LoadData.amp == $past(osc1Amp_q)) && (osc1LoadData.freq == $past(osc1Freq_q)))
    else $error("Normal reload not used with mode off");

  AST_LOAD_PULSE: assert property (
    osc1TimerExpire |=> osc1Load ##1 ($past(osc1TimerExpire) == osc1Load))
    else $error("Load pulse does not follow expiry");

  // Register bus checks
  AST_BUS_READY: assert property (
    $past(rstn) |-> (hreadyout && !hresp))
    else $error("Slave not ready or response not OKAY");

  AST_UNMAPPED_WRITE_DROP: assert property (
    (addrTake && addrHigh) |=> !dphaseValid_q)
    else $error("Unmapped access opened a data phase");

  AST_UNMAPPED_READ_ZERO: assert property (
    (addrTake && !hwrite && addrHigh) |=> (hrdata == `FSKR_RST_WORD))
    else $error("Unmapped read did not return zero");

  AST_COEFF_WRITE: assert property (
    wrSpAmp |=> (spaceAmp_q == $past(hwdata[15:0])))
    else $error("Coefficient write did not land");

  AST_FSK_CTRL_WRITE: assert property (
    wrFskCtl |=> (fskEnable_q == $past(hwdata[`FSKR_BIT_FSK_EN])))
    else $error("FSK enable bit not written");

  AST_OSC_CTRL_WRITE: assert property (
    wrOscCtl |=> (reloadEnable_q == $past(hwdata[`FSKR_BIT_RELOAD_EN])))
    else $error("Reload enable bit not written");

  AST_STATUS_READ: assert property (
    (addrTake && !hwrite && !addrHigh && (addrIndex == `FSKR_IDX_STATUS))
      |=> (hrdata == $past(statusWord)))
    else $error("Status read does not show the mode");

  AST_HRDATA_HOLDS: assert property (
    !(addrTake && !hwrite) |=> $stable(hrdata))
    else $error("Read data changed without a read");

  AST_CTRL_RESERVED_ZERO: assert property (
    (addrTake && !hwrite && !addrHigh && (addrIndex == `FSKR_IDX_FSK_CTRL))
      |=> (hrdata[5:0] == 6'h00) && (hrdata[31:7] == 25'h000_0000))
    else $error("Control read shows bits other than the enable");

  // Reload link checks
  AST_LOAD_HOLDS: assert property (
    !osc1TimerExpire |=> $stable(osc1LoadData))
    else $error("Load data changed without an expiry");

  AST_NO_LOAD_IDLE: assert property (
    !osc1TimerExpire |=> !osc1Load)
    else $error("Load pulse without an expiry");

  AST_SYMBOL_ECHO: assert property (
    osc1TimerExpire |=> (osc1LoadData.symbol == $past(fskSymbol)))
    else $error("Load data carries the wrong symbol");

  AST_GAIN_ZERO_IDLE: assert property (
    (osc1Load && !osc1LoadData.gainValid) |-> (osc1LoadData.gain == `FSKR_RST_COEFF))
    else $error("Gain factor passed without a transition");

  AST_GAIN_NEEDS_MODE: assert property (
    (osc1Load && osc1LoadData.gainValid) |-> osc1LoadData.enhanced)
    else $error("Gain factor applied with the mode off");

  AST_HISTORY_CLEARS: assert property (
    !enhanced |=> !symValid_q)
    else $error("Symbol history kept with the mode off");

  AST_LAST_SYM_TRACK: assert property (
    (osc1TimerExpire && enhanced) |=> (lastSym_q == $past(fskSymbol)))
    else $error("Last symbol not recorded");

  AST_HISTORY_SETS: assert property (
    (osc1TimerExpire && enhanced) |=> symValid_q)
    else $error("Symbol history not marked valid");

  AST_FIRST_ENH_NO_GAIN: assert property (
    (osc1TimerExpire && enhanced && !symValid_q) |=> !osc1LoadData.gainValid)
    else $error("Gain applied to the first symbol of the mode");

  // Main scenarios seen
  COV_SPACE_TO_MARK: cover property (osc1Load && osc1LoadData.gainValid && osc1LoadData.symbol);
  COV_MARK_TO_SPACE: cover property (osc1Load && osc1LoadData.gainValid && !osc1LoadData.symbol);
  COV_NORMAL_LOAD:   cover property (osc1Load && !osc1LoadData.enhanced);
  COV_MODE_ENABLE:   cover property ($rose(active_q) ##[1:50] osc1Load);
  COV_BACK_TO_BACK:  cover property (osc1Load && osc1TimerExpire);

endmodule

// ==== tb/fskr_osc_reload_tb_top.sv ====
// Purpose: Self-checking bench for the FSK reload block
// Assumes: Zero-wait AHB-Lite slave; hready is looped back from hreadyout
// Notes:   Coefficients and symbols come from an xorshift generator seeded at 41
`timescale 1ns/10ps
`include "fskr_regs.svh"

module fskr_osc_reload_tb_top import fskr_pkg::*;;
  logic        clk_sys, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic        osc1TimerExpire, fskSymbol, osc1Load, fEn, rEn, histV, lastSym;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] cf [0:7];
  fskr_load_t  osc1LoadData;
  int          errCount, cmpCount;
  localparam logic [9:0] IDX [0:7] = '{`FSKR_IDX_SPACE_AMP, `FSKR_IDX_SPACE_FREQ,
    `FSKR_IDX_MARK_AMP, `FSKR_IDX_MARK_FREQ, `FSKR_IDX_S2M_GAIN, `FSKR_IDX_M2S_GAIN,
    `FSKR_IDX_FREQUENCY_COEFF_A_AMP, `FSKR_IDX_FREQUENCY_COEFF_A_FREQ};

  assign hready = hreadyout;  // Single slave drives the bus ready

  fskr_osc_reload dut (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc1TimerExpire(osc1TimerExpire),
    .fskSymbol(fskSymbol), .osc1Load(osc1Load), .osc1LoadData(osc1LoadData)
  );

  // Clock at 20 MHz
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] ad(input logic [9:0] i);
    return {20'h0, i, 2'b00};
  endfunction

  task automatic stopTest;
    $display("Comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic waitRdy;
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      if (hready === 1'b1) break;
    end
    if (k == 40) begin
      errCount++;
      $display("Error hready expected 1 seen %b", hready);
      stopTest;
    end
  endtask

  // One single-word AHB transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    waitRdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitRdy;
    d = hrdata;
  endtask

  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk("hrdata", e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Program both enables, with all other control bits set to show they read zero
  task automatic setEn(input logic f, input logic r);
    fEn = f;
    rEn = r;
    if (!(f & r)) histV = 1'b0;
    ahb(1'b1, ad(`FSKR_IDX_OSC_CTRL), 32'hffff_ffbf | {25'h0, r, 6'h0}, rd);
    ahb(1'b1, ad(`FSKR_IDX_FSK_CTRL), 32'hffff_ffbf | {25'h0, f, 6'h0}, rd);
    rdChk(ad(`FSKR_IDX_OSC_CTRL), {25'h0, r, 6'h0});
    rdChk(ad(`FSKR_IDX_FSK_CTRL), {25'h0, f, 6'h0});
  endtask

  // Expected load for one expiry, with the symbol history kept by the bench
  task automatic checkLoad(input logic s);
    logic gv;
    chk("osc1Load", 32'h1, {31'h0, osc1Load});
    chk("symbol", {31'h0, s}, {31'h0, osc1LoadData.symbol});
    if (!(fEn & rEn)) begin
      histV = 1'b0;
      chk("amp", {16'h0, cf[6]}, {16'h0, osc1LoadData.amp});
      chk("freq", {16'h0, cf[7]}, {16'h0, osc1LoadData.freq});
      chk("gainValid", 32'h0, {31'h0, osc1LoadData.gainValid});
      chk("gain", 32'h0, {16'h0, osc1LoadData.gain});
      chk("enhanced", 32'h0, {31'h0, osc1LoadData.enhanced});
    end else begin
      gv = histV & (s != lastSym);
      chk("amp", {16'h0, s ? cf[2] : cf[0]}, {16'h0, osc1LoadData.amp});
      chk("freq", {16'h0, s ? cf[3] : cf[1]}, {16'h0, osc1LoadData.freq});
      chk("enhanced", 32'h1, {31'h0, osc1LoadData.enhanced});
      chk("gainValid", {31'h0, gv}, {31'h0, osc1LoadData.gainValid});
      chk("gain", {16'h0, gv ? (s ? cf[4] : cf[5]) : 16'h0}, {16'h0, osc1LoadData.gain});
      histV = 1'b1;
      lastSym = s;
    end
  endtask

  // Back-to-back expiries, one symbol per cycle from bit 0 upward
  task automatic burst(input int n, input logic [7:0] s);
    @(posedge clk_sys);
    osc1TimerExpire <= 1'b1;
    fskSymbol       <= s[0];
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      fskSymbol <= s[3'(i + 1)];
      if (i == n - 1) osc1TimerExpire <= 1'b0;
      #1;
      checkLoad(s[3'(i)]);
    end
    @(posedge clk_sys);
    #1;
    chk("osc1Load", 32'h0, {31'h0, osc1Load});
  endtask

  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    $display("Error watchdog expected done seen running");
    stopTest;
  end

  // Main sequence
  initial begin
    {rstn, hsel, hwrite, osc1TimerExpire, fskSymbol, fEn, rEn, histV, lastSym} = '0;
    {haddr, hwdata, rd} = '0;
    htrans = 2'b00;
    hsize  = 3'b010;
    errCount = 0;
    cmpCount = 0;
    seed = 32'd41;
    repeat (6) @(posedge clk_sys);
    chk("hreadyout", 32'h0, {31'h0, hreadyout});
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("osc1Load", 32'h0, {31'h0, osc1Load});
    chk("osc1LoadData", 32'h0, {31'h0, |osc1LoadData});
    chk("hrdata", 32'h0, hrdata);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      cf[i] = seed[15:0];
      ahb(1'b1, ad(IDX[i]), seed, rd);
    end
    for (int i = 0; i < 8; i++) rdChk(ad(IDX[i]), {16'h0, cf[i]});
    // Unmapped alias of a coefficient register must not write or read it
    ahb(1'b1, 32'h0000_1000 | ad(IDX[0]), 32'h1234_5678, rd);
    rdChk(32'h0000_1000 | ad(IDX[0]), 32'h0);
    rdChk(ad(IDX[0]), {16'h0, cf[0]});
    for (int m = 0; m < 4; m++) begin
      setEn(m[1], m[0]);
      seed = xs(seed);
      burst(3, seed[7:0]);
    end
    burst(4, 8'h0b);
    rdChk(ad(`FSKR_IDX_STATUS), {29'h0, histV, lastSym, fEn & rEn});
    for (int k = 0; k < 10; k++) begin
      seed = xs(seed);
      if (seed[9:8] == 2'b00) setEn(seed[10], seed[11]);
      if (seed[15]) begin
        cf[4 + int'(seed[16])] = seed[31:16];
        ahb(1'b1, ad(IDX[4 + int'(seed[16])]), {16'h0, seed[31:16]}, rd);
      end
      burst(int'(seed[14:12]) + 1, seed[7:0]);
    end
    stopTest;
  end
endmodule
